// >>> design/multiply_accumulate_unit.sv
// Multiply-accumulate execution unit beside the core's operand pipeline
`timescale 1ns/100ps
//
// Contract
// - Accumulate overflow beyond 32 bits sets overflow flag.
// - Overflow sticky until accumulator or status written.
// - Plain multiplies leave overflow flag unchanged.
// - Carry bit reads zero, writes ignored.
// - Masked loads AND mask with low address.
// - Per-mode masked output and writeback addresses.
// - Unsigned right shift inserts zero.
// - Signed word right shift inserts sign unless zero.
// - Signed long inserts zero on overflow or zero.
// - Saturation on multiply overflow sets flag, clamps.
// - Signed clamp by product sign and operation.
// - Unsigned clamp ones on add, zeros subtract.
// - Saturated accumulator held until flag cleared.
// - Multiplies 16x16 or 32x32 give 32-bit result.
// - Accumulate adds or subtracts shifted product, parallel load.
// - Saturate enable bit, zero after reset.
// - Unsigned mode bit, zero after reset.
// - Accumulate updates negative and zero flags.
module multiply_accumulate_unit
  import mac_pkg::*;
#(
  parameter int LONG_OP_CYCLES = LONG_CYCLES  // Issue interval of longword operations
)(
  input  wire logic        clk_sys,        // System clock, 250 MHz
  input  wire logic        srst,           // Synchronous reset, active high
  input  wire logic        clkEn,          // Clock enable, freezes all state when low
  input  wire logic        opValid,        // Instruction issue strobe
  input  wire op_t         opCode,         // Instruction code
  input  wire logic        opLong,         // Longword operands
  input  wire shift_t      opShift,        // Product shift
  input  wire logic        opLoad,         // Load variant with parallel load
  input  wire logic        opMask,         // Mask addressing modifier
  input  wire ea_t         opEaMode,       // Addressing mode of load
  input  wire logic [31:0] opA,            // Operand Rx / source data
  input  wire logic [31:0] opB,            // Operand Ry
  input  wire logic [31:0] addrReg,        // Address register An
  input  wire logic [15:0] disp16,         // Displacement
  output logic             busy,           // Unit refuses issue
  output logic             resultValid,    // Result data valid pulse
  output logic      [31:0] resultData,     // Multiply or move result
  output logic             loadAddrValid,  // Load address valid pulse
  output logic      [31:0] loadAddr,       // Output address of load
  output logic             addrWbValid,    // An writeback valid pulse
  output logic      [31:0] addrWb,         // New An value
  output logic      [31:0] accValue,       // product_accumulator
  output logic       [7:0] statusValue,    // accum_status_reg
  output logic      [15:0] maskValue       // load_address_mask
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (LONG_OP_CYCLES < 2 || LONG_OP_CYCLES > 15) begin : g_chk
    $error("LONG_OP_CYCLES must be within 2 to 15");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  op_t          cOp_reg;        // Latched instruction
  logic         cLong_reg;      // Latched longword flag
  shift_t       cShift_reg;     // Latched shift
  logic         cLoad_reg;      // Latched load flag
  logic         cMask_reg;      // Latched mask modifier
  ea_t          cEa_reg;        // Latched addressing mode
  logic [31:0]  cA_reg;         // Latched operand A
  logic [31:0]  cB_reg;         // Latched operand B
  logic [31:0]  cAn_reg;        // Latched address register
  logic [15:0]  cDisp_reg;      // Latched displacement
  logic         execValid_reg;  // Instruction waiting for commit
  logic  [3:0]  cnt_reg;        // Remaining iteration cycles
  logic         issue;          // Issue accepted
  logic         commit;         // Latched instruction commits now
  logic         isMacOp;        // Committing accumulate
  logic         isSub;          // Subtract form
  logic         macUns;         // Accumulate in unsigned mode
  logic [31:0]  prod;           // Shifted product
  logic         mulOvf;         // Multiply overflow
  logic         prodNeg;        // Product sign
  logic [32:0]  sum;            // Accumulator result with extra bit
  logic         accOvf;         // Accumulate overflow
  logic [31:0]  satVal;         // Clamp value
  logic         satOn;          // Saturation enabled
  logic         ovfFlag;        // Sticky overflow flag

  assign satOn   = statusValue[SR_SAT_BIT];
  assign ovfFlag = statusValue[SR_OVF_BIT];
  assign issue   = opValid && !busy && clkEn;
  assign commit  = execValid_reg && (cnt_reg == 4'h0) && clkEn;
  assign isMacOp = (cOp_reg == OP_MAC) || (cOp_reg == OP_MULTIPLY_SUBTRACT);
  assign isSub   = (cOp_reg == OP_MULTIPLY_SUBTRACT);
  assign macUns  = isMacOp ? statusValue[SR_UNS_BIT] : (cOp_reg == OP_MUL_U);

  // Address masking of the low word only
  function automatic logic [31:0] maskAddr(input logic [31:0] a, input logic [15:0] m, input logic en);
    maskAddr = en ? (a & {ADDR_UPPER, m}) : a;
  endfunction

  // ----------------------------------------------------------------
  // Product datapath
  // ----------------------------------------------------------------
  mac_product u_prod (
    .opX      (cA_reg),
    .opY      (cB_reg),
    .isLong   (cLong_reg),
    .isUns    (macUns),
    .shiftSel (isMacOp ? cShift_reg : SH_NONE),
    .product  (prod),
    .mulOvf   (mulOvf),
    .prodNeg  (prodNeg)
  );

  // ----------------------------------------------------------------
  // Accumulate arithmetic and clamp selection
  // ----------------------------------------------------------------
  always_comb begin
    if (macUns) begin
      sum    = isSub ? ({1'b0, accValue} - {1'b0, prod}) : ({1'b0, accValue} + {1'b0, prod});
      accOvf = sum[32];
      satVal = isSub ? SAT_ZERO : SAT_ONES;
    end else begin
      sum    = isSub ? ({accValue[31], accValue} - {prod[31], prod})
                     : ({accValue[31], accValue} + {prod[31], prod});
      accOvf = sum[32] ^ sum[31];
      satVal = (prodNeg ^ isSub) ? SAT_NEG : SAT_POS;
    end
  end

  // ----------------------------------------------------------------
  // Command latch and iteration counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cOp_reg       <= OP_NOP;
      cLong_reg     <= 1'b0;
      cShift_reg    <= SH_NONE;
      cLoad_reg     <= 1'b0;
      cMask_reg     <= 1'b0;
      cEa_reg       <= EA_IND;
      cA_reg        <= 32'h0000_0000;
      cB_reg        <= 32'h0000_0000;
      cAn_reg       <= 32'h0000_0000;
      cDisp_reg     <= 16'h0000;
      execValid_reg <= 1'b0;
      cnt_reg       <= 4'h0;
      busy          <= 1'b0;
    end else if (clkEn) begin
      if (issue) begin
        // Latch new instruction; longword multiplies iterate
        cOp_reg       <= opCode;
        cLong_reg     <= opLong;
        cShift_reg    <= opShift;
        cLoad_reg     <= opLoad;
        cMask_reg     <= opMask;
        cEa_reg       <= opEaMode;
        cA_reg        <= opA;
        cB_reg        <= opB;
        cAn_reg       <= addrReg;
        cDisp_reg     <= disp16;
        execValid_reg <= 1'b1;
        if (opLong && opCode inside {OP_MUL_S, OP_MUL_U, OP_MAC, OP_MULTIPLY_SUBTRACT}) begin
          cnt_reg <= 4'(LONG_OP_CYCLES - 1);
          busy    <= 1'b1;
        end else begin
          cnt_reg <= 4'h0;
          busy    <= 1'b0;
        end
      end else if (cnt_reg != 4'h0) begin
        // Iterating longword operation
        cnt_reg <= cnt_reg - 4'h1;
        busy    <= (cnt_reg != 4'h1);
      end else if (commit) begin
        execValid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, status and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      accValue    <= ACC_RESET;
      statusValue <= SR_RESET;
      maskValue   <= MASK_RESET;
    end else if (commit) begin
      case (cOp_reg)
        OP_MAC, OP_MULTIPLY_SUBTRACT: begin
          if (satOn && ovfFlag) begin
            // Saturated value held until flag cleared
            accValue <= accValue;
          end else if (satOn && (mulOvf || accOvf)) begin
            accValue                 <= satVal;
            statusValue[SR_OVF_BIT]  <= 1'b1;
            statusValue[SR_NEG_BIT]  <= satVal[31];
            statusValue[SR_ZERO_BIT] <= (satVal == 32'h0000_0000);
          end else begin
            accValue                 <= sum[31:0];
            statusValue[SR_OVF_BIT]  <= ovfFlag || mulOvf || accOvf;
            statusValue[SR_NEG_BIT]  <= sum[31];
            statusValue[SR_ZERO_BIT] <= (sum[31:0] == 32'h0000_0000);
          end
        end
        OP_TO_ACC: begin
          accValue                <= cA_reg;
          statusValue[SR_OVF_BIT] <= 1'b0;
        end
        OP_TO_SR: begin
          // Carry and reserved bits stay zero
          statusValue <= cA_reg[7:0] & SR_WRITE_MASK;
        end
        OP_TO_MASK: begin
          maskValue <= cA_reg[15:0];
        end
        default: begin
          // Multiplies and reads leave the registers alone
          statusValue <= statusValue;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result port and load address generation
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resultValid   <= 1'b0;
      resultData    <= 32'h0000_0000;
      loadAddrValid <= 1'b0;
      loadAddr      <= 32'h0000_0000;
      addrWbValid   <= 1'b0;
      addrWb        <= 32'h0000_0000;
    end else if (clkEn) begin
      resultValid   <= 1'b0;
      loadAddrValid <= 1'b0;
      addrWbValid   <= 1'b0;
      if (commit) begin
        case (cOp_reg)
          OP_MUL_S, OP_MUL_U: begin
            resultValid <= 1'b1;
            resultData  <= prod;
          end
          OP_FROM_ACC: begin
            resultValid <= 1'b1;
            resultData  <= accValue;
          end
          OP_FROM_SR: begin
            resultValid <= 1'b1;
            resultData  <= {24'h00_0000, statusValue};
          end
          OP_SR_TO_CCR: begin
            resultValid <= 1'b1;
            resultData  <= {28'h000_0000, statusValue[3:0]};
          end
          OP_FROM_MASK: begin
            resultValid <= 1'b1;
            resultData  <= {16'h0000, maskValue};
          end
          OP_MAC, OP_MULTIPLY_SUBTRACT: begin
            if (cLoad_reg) begin
              loadAddrValid <= 1'b1;
              case (cEa_reg)
                EA_POSTINC: begin
                  loadAddr    <= cAn_reg;
                  addrWbValid <= 1'b1;
                  addrWb      <= maskAddr(cAn_reg + ADDR_STEP, maskValue, cMask_reg);
                end
                EA_PREDEC: begin
                  loadAddr    <= maskAddr(cAn_reg - ADDR_STEP, maskValue, cMask_reg);
                  addrWbValid <= 1'b1;
                  addrWb      <= maskAddr(cAn_reg - ADDR_STEP, maskValue, cMask_reg);
                end
                EA_DISP: begin
                  loadAddr <= maskAddr(cAn_reg + {{16{cDisp_reg[15]}}, cDisp_reg}, maskValue, cMask_reg);
                end
                default: begin
                  loadAddr <= maskAddr(cAn_reg, maskValue, cMask_reg);
                end
              endcase
            end
          end
          default: begin
            resultValid <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_macCommit;
    commit && isMacOp;
  endsequence

  sequence s_longIssue;
    issue && opLong && (opCode == OP_MAC);
  endsequence

  property p_accOvfSets;
    s_macCommit ##0 (!satOn && accOvf) |=> statusValue[SR_OVF_BIT];
  endproperty
  a_accOvfSets: assert property (p_accOvfSets) else $error("overflow flag not set");

  property p_ovfSticky;
    (ovfFlag && !(commit && (cOp_reg inside {OP_TO_ACC, OP_TO_SR}))) |=> ovfFlag;
  endproperty
  a_ovfSticky: assert property (p_ovfSticky) else $error("overflow flag cleared early");

  property p_mulKeepsFlags;
    (commit && (cOp_reg inside {OP_MUL_S, OP_MUL_U})) |=> $stable(statusValue) && resultValid;
  endproperty
  a_mulKeepsFlags: assert property (p_mulKeepsFlags) else $error("multiply changed status");

  property p_carryZero;
    statusValue[SR_CARRY_BIT] == 1'b0;
  endproperty
  a_carryZero: assert property (p_carryZero) else $error("carry bit not zero");

  property p_predecMask;
    (commit && isMacOp && cLoad_reg && cMask_reg && (cEa_reg == EA_PREDEC))
      |=> (loadAddr == (($past(cAn_reg) - 32'h0000_0004) & {16'hFFFF, $past(maskValue)})) && (addrWb == loadAddr);
  endproperty
  a_predecMask: assert property (p_predecMask) else $error("predecrement address wrong");

  property p_unsSatAdd;
    s_macCommit ##0 (macUns && satOn && !ovfFlag && mulOvf && !isSub) |=> accValue == 32'hFFFF_FFFF && ovfFlag;
  endproperty
  a_unsSatAdd: assert property (p_unsSatAdd) else $error("unsigned clamp wrong");

  property p_sgnSatPos;
    s_macCommit ##0 (!macUns && satOn && !ovfFlag && mulOvf && !isSub && !prodNeg) |=> accValue == 32'h7FFF_FFFF;
  endproperty
  a_sgnSatPos: assert property (p_sgnSatPos) else $error("signed clamp wrong");

  property p_satHold;
    s_macCommit ##0 (satOn && ovfFlag) |=> $stable(accValue);
  endproperty
  a_satHold: assert property (p_satHold) else $error("saturated value changed");

  property p_nzFlags;
    s_macCommit ##0 !(satOn && ovfFlag)
      |=> (statusValue[SR_NEG_BIT] == accValue[31]) && (statusValue[SR_ZERO_BIT] == (accValue == 32'h0000_0000));
  endproperty
  a_nzFlags: assert property (p_nzFlags) else $error("negative or zero flag wrong");

  property p_longBusy;
    s_longIssue ##1 clkEn[*2] |=> !busy ##0 $past(busy, 2);
  endproperty
  a_longBusy: assert property (p_longBusy) else $error("long issue interval wrong");

endmodule // multiply_accumulate_unit

// >>> include/mac_pkg.sv
// Shared constants and types of the multiply-accumulate unit
package mac_pkg;

  // ----------------------------------------------------------------
  // Instruction codes issued by the core's operand pipeline
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP,          // No operation
    OP_MUL_S,        // signed_multiply
    OP_MUL_U,        // unsigned_multiply
    OP_MAC,          // Accumulate add (accumulate_with_load when loading)
    OP_MULTIPLY_SUBTRACT,         // multiply_subtract (subtract_with_load when loading)
    OP_TO_ACC,       // Move to product_accumulator
    OP_TO_SR,        // Move to accum_status_reg
    OP_TO_MASK,      // Move to load_address_mask
    OP_FROM_ACC,     // Move from product_accumulator
    OP_FROM_SR,      // Move from accum_status_reg
    OP_SR_TO_CCR,    // Move status flags to condition_code_reg
    OP_FROM_MASK     // Move from load_address_mask
  } op_t;

  // Product shift selection
  typedef enum logic [1:0] {
    SH_NONE,
    SH_LEFT,
    SH_RIGHT
  } shift_t;

  // Effective addressing mode of a load variant
  typedef enum logic [1:0] {
    EA_IND,          // (An)
    EA_POSTINC,      // (An)+
    EA_PREDEC,       // -(An)
    EA_DISP          // (d16,An)
  } ea_t;

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int        SR_SAT_BIT    = 7;
  localparam int        SR_UNS_BIT    = 6;
  localparam int        SR_NEG_BIT    = 3;
  localparam int        SR_ZERO_BIT   = 2;
  localparam int        SR_OVF_BIT    = 1;
  localparam int        SR_CARRY_BIT  = 0;
  localparam logic [7:0] SR_WRITE_MASK = 8'h00CE;
  localparam logic [7:0] SR_RESET      = 8'h0000;
  localparam logic [31:0] ACC_RESET    = 32'h0000_0000;
  localparam logic [15:0] MASK_RESET   = 16'hFFFF;

  // ----------------------------------------------------------------
  // Arithmetic and timing constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SAT_POS      = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG      = 32'h8000_0000;
  localparam logic [31:0] SAT_ONES     = 32'hFFFF_FFFF;
  localparam logic [31:0] SAT_ZERO     = 32'h0000_0000;
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
  localparam logic [15:0] ADDR_UPPER   = 16'hFFFF;
  localparam int          LONG_CYCLES  = 3;

endpackage

// >>> design/mac_product.sv
// Product generation with overflow detection and one-bit shift
`timescale 1ns/100ps
module mac_product
  import mac_pkg::*;
(
  input  wire logic [31:0] opX,       // First operand
  input  wire logic [31:0] opY,       // Second operand
  input  wire logic        isLong,    // 32x32 when high, 16x16 low words when low
  input  wire logic        isUns,     // Unsigned operands when high
  input  wire shift_t      shiftSel,  // Product shift
  output logic      [31:0] product,   // Shifted 32-bit product
  output logic             mulOvf,    // Product does not fit 32 bits
  output logic             prodNeg    // Sign of the true product
);

  // ----------------------------------------------------------------
  // Operand extension to 33 bits
  // ----------------------------------------------------------------
  function automatic logic [32:0] extOp(input logic [31:0] v, input logic lng, input logic uns);
    logic s;
    s = lng ? (!uns && v[31]) : (!uns && v[15]);
    extOp = lng ? {s, v} : {{17{s}}, v[15:0]};
  endfunction

  logic signed [65:0] full;   // Full-width product
  logic        [31:0] low;    // Low word of product
  logic               fill;   // Bit inserted on right shift

  // ----------------------------------------------------------------
  // Multiply, overflow and shift
  // ----------------------------------------------------------------
  always_comb begin
    full    = $signed(extOp(opX, isLong, isUns)) * $signed(extOp(opY, isLong, isUns));
    low     = full[31:0];
    // Overflow when upper part is not an extension of the low word
    mulOvf  = isUns ? (|full[65:32]) : !((&full[65:31]) || !(|full[65:31]));
    prodNeg = !isUns && full[65];
    // Zero for unsigned, sign unless zero product or long overflow
    fill    = 1'b0;
    if (!isUns && (low != 32'h0000_0000) && !(isLong && mulOvf)) begin
      fill = full[65];
    end
    case (shiftSel)
      SH_LEFT:  product = {low[30:0], 1'b0};
      SH_RIGHT: product = {fill, low[31:1]};
      default:  product = low;
    endcase
  end

endmodule // mac_product

// >>> verification/core_pipeline_model.sv
// Operand pipeline model that issues instructions to the unit
`timescale 1ns/100ps
module core_pipeline_model
  import mac_pkg::*;
(
  input  wire logic   clk_sys,   // System clock
  input  wire logic   busy,      // Unit refuses issue
  output logic        opValid,   // Issue strobe
  output op_t         opCode,    // Instruction code
  output logic        opLong,    // Longword operands
  output shift_t      opShift,   // Product shift
  output logic        opLoad,    // Load variant
  output logic        opMask,    // Mask modifier
  output ea_t         opEaMode,  // Load addressing mode
  output logic [31:0] opA,       // Rx or move source
  output logic [31:0] opB,       // Ry
  output logic [31:0] addrReg,   // An
  output logic [15:0] disp16     // Displacement
);
  // ----------------------------------------------------------------
  // Idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    {opValid, opLong, opLoad, opMask} = 4'h0;
    opCode = OP_NOP;
    opShift = SH_NONE;
    opEaMode = EA_IND;
    {opA, opB, addrReg, disp16} = 112'h0;
  end

  // Holds the request until an edge with busy low, then scrambles the released data
  task automatic issue(input op_t c, input logic lg, input shift_t sh, input logic ld,
                       input ea_t ea, input logic [31:0] a, b, an, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    {opValid, opLong, opLoad, opMask} = {1'b1, lg, ld, ld};
    opCode = c;
    opShift = sh;
    opEaMode = ea;
    {opA, opB, addrReg, disp16} = {a, b, an, d};
    @(posedge clk_sys);
    while (busy) begin
      @(posedge clk_sys);
    end
    #1;
    {opValid, opLong, opLoad, opMask} = 4'h0;
    opCode = OP_NOP;
    {opA, opB, addrReg, disp16} = ~{opA, opB, addrReg, disp16};
  endtask
endmodule // core_pipeline_model

// >>> verification/multiply_accumulate_unit_bench.sv
// Self-checking bench of the multiply-accumulate unit
`timescale 1ns/100ps
module multiply_accumulate_unit_bench;
  import mac_pkg::*;
  logic clk_sys, srst, clkEn, opValid, opLong, opLoad, opMask, busy;
  logic resultValid, loadAddrValid, addrWbValid;
  op_t opCode;
  shift_t opShift;
  ea_t opEaMode;
  logic [31:0] opA, opB, addrReg, resultData, loadAddr, addrWb, accValue, a, b, an, s;
  logic [15:0] disp16, maskValue, d;
  logic [7:0] statusValue;
  logic signed [31:0] sw;
  logic [31:0] expR[$], expL[$], expW[$]; // Expected results in order
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;

  multiply_accumulate_unit u_multiply_accumulate_unit (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn),
    .opValid(opValid), .opCode(opCode), .opLong(opLong), .opShift(opShift), .opLoad(opLoad),
    .opMask(opMask), .opEaMode(opEaMode), .opA(opA), .opB(opB), .addrReg(addrReg), .disp16(disp16),
    .busy(busy), .resultValid(resultValid), .resultData(resultData), .loadAddrValid(loadAddrValid),
    .loadAddr(loadAddr), .addrWbValid(addrWbValid), .addrWb(addrWb), .accValue(accValue),
    .statusValue(statusValue), .maskValue(maskValue));
  core_pipeline_model u_core (.clk_sys(clk_sys), .busy(busy), .opValid(opValid), .opCode(opCode),
    .opLong(opLong), .opShift(opShift), .opLoad(opLoad), .opMask(opMask), .opEaMode(opEaMode),
    .opA(opA), .opB(opB), .addrReg(addrReg), .disp16(disp16));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watcher: oldest note against each result pulse, plus hang limit
  always @(posedge clk_sys) begin
    cycles++;
    if (resultValid === 1'b1) chk("result", expR.size() ? expR.pop_front() : ~resultData, resultData);
    if (loadAddrValid === 1'b1) chk("loadAddr", expL.size() ? expL.pop_front() : ~loadAddr, loadAddr);
    if (addrWbValid === 1'b1) chk("addrWb", expW.size() ? expW.pop_front() : ~addrWb, addrWb);
    if (cycles == 4000) begin
      failCount++;
      testDone();
    end
  end

  task automatic w(input op_t c, input logic [31:0] x, y, input logic lg = 1'b0);
    u_core.issue(c, lg, SH_NONE, 1'b0, EA_IND, x, y, 32'h0000_0000, 16'h0000);
  endtask

  task automatic rd(input op_t c, input logic [31:0] e);
    expR.push_back(e);
    w(c, 32'h0000_0000, 32'h0000_0000);
  endtask

  task automatic macChk(input logic [31:0] sr, acc0, input op_t c, input logic lg, input shift_t sh,
                        input logic [31:0] x, y, e);
    w(OP_TO_SR, sr, 32'h0000_0000);
    w(OP_TO_ACC, acc0, 32'h0000_0000);
    u_core.issue(c, lg, sh, 1'b0, EA_IND, x, y, 32'h0000_0000, 16'h0000);
    rd(OP_FROM_ACC, e);
  endtask

  initial begin
    srst = 1'b1;
    clkEn = 1'b1;
    void'($urandom(32'hc49ffbcc));
    repeat (4) @(posedge clk_sys);
    #1 srst = 1'b0;
    rd(OP_FROM_SR, 32'h0000_0000);
    rd(OP_FROM_MASK, 32'h0000_FFFF);
    $display("test reset done");
    w(OP_TO_SR, 32'h0000_00FF, 32'h0000_0000);
    rd(OP_FROM_SR, 32'h0000_00CE);
    a = $urandom;
    b = $urandom;
    sw = $signed(a[15:0]) * $signed(b[15:0]);
    expR.push_back(sw);
    w(OP_MUL_S, a, b);
    expR.push_back(a * b);
    w(OP_MUL_U, a, b, 1'b1);
    rd(OP_SR_TO_CCR, 32'h0000_000E);
    $display("test multiply done");
    macChk(32'h0000_0000, 32'h7FFF_FFF0, OP_MAC, 1'b0, SH_NONE, 32'h1, 32'h20, 32'h8000_0010);
    rd(OP_FROM_SR, 32'h0000_000A);
    w(OP_MAC, 32'h0000_0000, 32'h0000_0000);
    rd(OP_FROM_SR, 32'h0000_000A);
    w(OP_TO_ACC, 32'h0000_0000, 32'h0000_0000);
    w(OP_MAC, 32'h0000_0000, 32'h0000_0000);
    rd(OP_FROM_SR, 32'h0000_0004);
    $display("test overflow flag done");
    macChk(32'h0, 32'h5, OP_MULTIPLY_SUBTRACT, 1'b0, SH_NONE, 32'h2, 32'h3, 32'hFFFF_FFFF);
    macChk(32'h0, 32'h0, OP_MAC, 1'b0, SH_LEFT, 32'h3, 32'h2, 32'h0000_000C);
    macChk(32'h0, 32'h0, OP_MAC, 1'b0, SH_RIGHT, 32'hFFFD, 32'h1, 32'hFFFF_FFFE);
    macChk(32'h0, 32'h0, OP_MAC, 1'b0, SH_RIGHT, 32'h0, 32'h5, 32'h0000_0000);
    macChk(32'h40, 32'h0, OP_MAC, 1'b0, SH_RIGHT, 32'hFFFF, 32'hFFFF, 32'h7FFF_0000);
    macChk(32'h40, 32'h0, OP_MAC, 1'b1, SH_RIGHT, 32'hFFFF_FFFF, 32'h1, 32'h7FFF_FFFF);
    macChk(32'h0, 32'h0, OP_MAC, 1'b1, SH_RIGHT, 32'hFFFF_FFFA, 32'h1, 32'hFFFF_FFFD);
    $display("test shift done");
    macChk(32'h80, 32'h0, OP_MAC, 1'b1, SH_NONE, 32'h1_0000, 32'h1_0000, SAT_POS);
    rd(OP_FROM_SR, 32'h0000_0082);
    w(OP_MAC, 32'h0000_0001, 32'h0000_0001);
    rd(OP_FROM_ACC, SAT_POS);
    macChk(32'h80, 32'h0, OP_MULTIPLY_SUBTRACT, 1'b1, SH_NONE, 32'h1_0000, 32'h1_0000, SAT_NEG);
    macChk(32'h80, 32'h0, OP_MAC, 1'b1, SH_NONE, 32'hFFFF_0000, 32'h1_0000, SAT_NEG);
    macChk(32'h80, 32'h0, OP_MULTIPLY_SUBTRACT, 1'b1, SH_NONE, 32'hFFFF_0000, 32'h1_0000, SAT_POS);
    macChk(32'hC0, 32'h5, OP_MAC, 1'b1, SH_NONE, 32'h1_0000, 32'h1_0000, SAT_ONES);
    macChk(32'hC0, 32'h5, OP_MULTIPLY_SUBTRACT, 1'b1, SH_NONE, 32'h1_0000, 32'h1_0000, SAT_ZERO);
    $display("test saturation done");
    w(OP_TO_MASK, 32'h0000_00F0, 32'h0000_0000);
    rd(OP_FROM_MASK, 32'h0000_00F0);
    for (int m = 0; m < 4; m++) begin
      an = $urandom;
      d = 16'($urandom);
      s = (m == 3) ? an + {{16{d[15]}}, d} : (m == 2) ? an - 32'h4 : an;
      expL.push_back(m == 1 ? an : s & 32'hFFFF_00F0);
      if (m == 1 || m == 2) expW.push_back((m == 1 ? an + 32'h4 : s) & 32'hFFFF_00F0);
      u_core.issue(OP_MAC, 1'b0, SH_NONE, 1'b1, ea_t'(m[1:0]), 32'h0, 32'h0, an, d);
    end
    $display("test masked load done");
    repeat (20) @(posedge clk_sys);
    clkEn = 1'b0;
    w(OP_TO_ACC, 32'h0000_1234, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    #1 clkEn = 1'b1;
    rd(OP_FROM_ACC, SAT_ZERO);
    repeat (4) @(posedge clk_sys);
    chk("accValue", SAT_ZERO, accValue);
    chk("statusValue", 32'h0000_00C6, {24'h00_0000, statusValue});
    chk("maskValue", 32'h0000_00F0, {16'h0000, maskValue});
    chk("busy", 32'h0000_0000, {31'h0000_0000, busy});
    $display("test clock enable done");
    chk("pending", 32'h0000_0000, 32'(expR.size() + expL.size() + expW.size()));
    testDone();
  end
endmodule // multiply_accumulate_unit_bench
